// >>> logic/ast_uart_map.vh
// Register offsets, field positions, reset values and timing for the serial transceiver
`ifndef AST_UART_MAP_VH
`define AST_UART_MAP_VH
`define AST_ADDR_MODE 4'h0
`define AST_ADDR_STAT 4'h1
`define AST_ADDR_TXD 4'h2
`define AST_ADDR_RXD 4'h3
`define AST_ADDR_BAUD 4'h4
`define AST_MODE_EN 15
`define AST_MODE_RST 16'h0000
`define AST_STA_TXISEL 15
`define AST_STA_BRK 11
`define AST_STA_TXEN 10
`define AST_STA_TXFULL 9
`define AST_STA_TXEMPTY 8
`define AST_STA_ADDRESS_DETECT_ENABLE 5
`define AST_STA_RECEIVER_IDLE 4
`define AST_STA_PARITY_ERROR_FLAG 3
`define AST_STA_STOP_BIT_ERROR 2
`define AST_STA_RX_OVERRUN_FLAG 1
`define AST_STA_RXDA 0
`define AST_FIFO_DEPTH 3'h4
`define AST_FIFO_3 3'h3
`define AST_OVS 4'hf
`define AST_OVS_MID 4'h7
`define AST_FMT_8E 2'h1
`define AST_FMT_8O 2'h2
`define AST_FMT_9N 2'h3
`endif

// >>> logic/ast_uart.v
// Full-duplex asynchronous serial transceiver with 4-deep FIFOs
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "ast_uart_map.vh"
//
// Contract
// [RQ1] When enabled, drive tx pin as output, rx as input; tx idles high.
// [RQ2] Reset clears module_enable; disabled pins return to port control.
// [RQ3] Disable empties both FIFOs and resets the baud counter.
// [RQ4] Disable clears rx/tx status flags, sets idle flags, keeps configuration.
// [RQ5] Disable aborts activity; re-enable resumes with the held configuration.
// [RQ6] Two-bit format: 8N, 8E, 8O or 9N for transmit and receive.
// [RQ7] Stop count select gives one or two stop bits.
// [RQ8] Power-on format is 8 data bits, no parity, one stop bit.
// [RQ9] Software enables module before transmit, configures before enabling.
// [RQ10] Written word moves to shifter; starts on baud edge or at enable; this design starts the frame at the load without waiting for a tick.
// [RQ11] In 9-bit mode software writes word with upper seven bits clear.
// [RQ12] Transmit FIFO 9 bits by 4; full flag at status bit 9.
// [RQ13] Writes to a full transmit FIFO are dropped; contents unchanged.
// [RQ14] Device reset empties both FIFOs; power modes do not touch them.
// [RQ15] Tx interrupt on each FIFO-to-shifter move, or only when FIFO empties.
// [RQ16] Send break forces tx low, overriding transmitter, no interrupt.
// [RQ17] Software waits idle, holds break 13 baud clocks, then waits stops.
// [RQ18] Reading rx data pops oldest word and updates its error flags.
// [RQ19] Overrun flag stays set until software clears it.
// [RQ20] Rx FIFO holds 4 words; data-available at bit 0 when nonempty.
// [RQ21] Reading an empty rx FIFO returns stale value without shifting.
// [RQ22] Rx interrupt each transfer, at 3 words, or at 4 words per select.
// [RQ23] Stop bit with full rx FIFO sets overrun and halts shifting.
// [RQ24] Interrupt edges are single-cycle pulses on the module clock.
// [RQ25] Frame: low start, data LSB first, optional parity, high stops.
module ast_uart (
    input wire i_mclk, // module clock, 10 MHz
    input wire i_resetn, // async reset, active low
    input wire [3:0] i_addr, // register index
    input wire [15:0] i_wdata, // write data
    input wire i_wr, // write strobe
    input wire i_rd, // read strobe
    output reg [15:0] o_rdata, // read data, cycle after strobe
    input wire i_serial_in_pin, // serial receive pin
    output wire o_serial_out_pin, // serial transmit level
    output wire o_serial_out_oe, // high while the module owns the tx pin
    output wire o_serial_in_own, // high while the module owns the rx pin
    output wire o_tx_irq, // transmit interrupt pulse
    output wire o_rx_irq // receive interrupt pulse
);
    reg [15:0] mode_q;
    reg [15:0] baud_q;
    reg txisel_q, brk_q, txen_q, address_detect_enable_q, rx_overrun_flag_q;
    reg [1:0] rxisel_q;
    wire en = mode_q[`AST_MODE_EN];
    wire stop_count_select = mode_q[0];
    wire [1:0] fmt = mode_q[2:1];
    wire wr_txd = i_wr && i_addr == `AST_ADDR_TXD;
    wire rd_rxd = i_rd && i_addr == `AST_ADDR_RXD;

    // Baud divider: 16x oversample tick
    reg [15:0] bcnt_q;
    wire tick = en && bcnt_q == 16'h0000;
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            bcnt_q <= 16'h0000;
        end else if (!en) begin
            bcnt_q <= 16'h0000; // see [RQ3]
        end else if (bcnt_q == 16'h0000) begin
            bcnt_q <= baud_q;
        end else begin
            bcnt_q <= bcnt_q - 16'h0001;
        end
    end

    // Transmit FIFO
    reg [8:0] tfifo [0:3];
    reg [1:0] twp_q, trp_q;
    reg [2:0] tcnt_q;
    wire tfull = tcnt_q == `AST_FIFO_DEPTH; // see [RQ12]
    reg tbusy_q;
    reg [3:0] tph_q;
    reg [3:0] tbit_q;
    reg [11:0] tsh_q;
    reg [3:0] tlen_q;
    reg tline_q;
    wire tload = en && txen_q && !tbusy_q && !brk_q && tcnt_q != 3'h0;
    wire [8:0] tword = tfifo[trp_q];
    wire tpar = ^tword[7:0] ^ (fmt == `AST_FMT_8O);
    always @(posedge i_mclk) begin
        if (wr_txd && !tfull && en) begin
            tfifo[twp_q] <= i_wdata[8:0];
        end
    end
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            twp_q <= 2'h0;
            trp_q <= 2'h0;
            tcnt_q <= 3'h0; // see [RQ14]
            tbusy_q <= 1'b0;
            tph_q <= 4'h0;
            tbit_q <= 4'h0;
            tsh_q <= 12'hfff;
            tlen_q <= 4'h0;
            tline_q <= 1'b1;
        end else if (!en) begin
            twp_q <= 2'h0; // see [RQ3]
            trp_q <= 2'h0;
            tcnt_q <= 3'h0;
            tbusy_q <= 1'b0; // see [RQ5]
            tph_q <= 4'h0;
            tline_q <= 1'b1;
        end else begin
            // Write to full FIFO dropped silently
            if ((wr_txd && !tfull) && !tload) begin // see [RQ13]
                twp_q <= twp_q + 2'h1;
                tcnt_q <= tcnt_q + 3'h1;
            end else if (tload && !(wr_txd && !tfull)) begin
                tcnt_q <= tcnt_q - 3'h1;
            end else if (wr_txd && !tfull) begin
                twp_q <= twp_q + 2'h1;
            end
            if (tload) begin // see [RQ10]
                trp_q <= trp_q + 2'h1;
                tbusy_q <= 1'b1;
                tph_q <= 4'h0;
                tbit_q <= 4'h0;
                tline_q <= 1'b0; // see [RQ25]
                case (fmt) // see [RQ6]
                    2'h0: begin
                        tsh_q <= {3'h7, tword[7:0], 1'b1};
                        tlen_q <= stop_count_select ? 4'ha : 4'h9; // see [RQ7]
                    end
                    2'h3: begin
                        tsh_q <= {2'h3, tword[8:0], 1'b1};
                        tlen_q <= stop_count_select ? 4'hb : 4'ha;
                    end
                    default: begin
                        tsh_q <= {2'h3, tpar, tword[7:0], 1'b1};
                        tlen_q <= stop_count_select ? 4'hb : 4'ha;
                    end
                endcase
            end else if (tbusy_q && tick) begin
                tph_q <= tph_q + 4'h1;
                if (tph_q == `AST_OVS) begin
                    if (tbit_q == tlen_q) begin
                        tbusy_q <= 1'b0;
                        tline_q <= 1'b1;
                    end else begin
                        tbit_q <= tbit_q + 4'h1;
                        tsh_q <= {1'b1, tsh_q[11:1]};
                        tline_q <= tsh_q[1];
                    end
                end
            end
        end
    end
    // Break wins over the shifter; a running frame is corrupted by design
    assign o_serial_out_pin = en ? (brk_q ? 1'b0 : tline_q) : 1'b1; // see [RQ16] [RQ1]
    assign o_serial_out_oe = en; // see [RQ1] [RQ2]
    assign o_serial_in_own = en;
    // A write landing with the load keeps the FIFO non-empty after the move
    wire tx_left_empty = tcnt_q == 3'h1 && !(wr_txd && !tfull);
    wire tx_ev = tload && (!txisel_q || tx_left_empty); // see [RQ15]

    // Receiver: three-flop input, change counts when stages two and three agree
    reg [2:0] rsync_q;
    reg rin_q;
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rsync_q <= 3'h7;
            rin_q <= 1'b1;
        end else begin
            rsync_q <= {rsync_q[1:0], i_serial_in_pin};
            if (rsync_q[2] == rsync_q[1]) begin
                rin_q <= rsync_q[2];
            end
        end
    end
    localparam RX_IDLE = 2'h0;
    localparam RX_DATA = 2'h1;
    localparam RX_WAIT = 2'h2;
    reg [1:0] rst_q;
    reg [3:0] rph_q;
    reg [3:0] rbit_q;
    reg [10:0] rsh_q;
    reg rferr_q;
    reg [10:0] rfifo [0:3];
    reg [1:0] rwp_q, rrp_q;
    reg [2:0] rcnt_q;
    reg [10:0] rhead_q;
    wire [3:0] rlen = (fmt == 2'h0) ? (stop_count_select ? 4'ha : 4'h9) : (stop_count_select ? 4'hb : 4'ha);
    wire [3:0] rstop1 = (fmt == 2'h0) ? 4'h9 : 4'ha;
    wire rsamp = tick && rph_q == `AST_OVS_MID;
    wire rdone = rst_q == RX_DATA && rsamp && rbit_q == rlen;
    wire rstopbad = rferr_q || !rin_q;
    wire rpop = rd_rxd && rcnt_q != 3'h0; // see [RQ21]
    wire rpush = rdone && rcnt_q != `AST_FIFO_DEPTH && !rx_overrun_flag_q;
    reg [8:0] rdat;
    reg rperr;
    always @* begin
        rdat = 9'h000;
        rperr = 1'b0;
        // Start bit sits just below the data once the last data or parity bit is in
        case (fmt)
            2'h0: begin
                rdat = {1'b0, rsh_q[10:3]};
            end
            2'h3: begin
                rdat = rsh_q[10:2];
            end
            default: begin
                rdat = {1'b0, rsh_q[9:2]};
                rperr = ^rsh_q[10:2] ^ (fmt == `AST_FMT_8O);
            end
        endcase
    end
    always @(posedge i_mclk) begin
        if (rpush) begin
            rfifo[rwp_q] <= {rperr, rstopbad, rdat};
        end
    end
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_q <= RX_IDLE;
            rph_q <= 4'h0;
            rbit_q <= 4'h0;
            rsh_q <= 11'h000;
            rferr_q <= 1'b0;
            rwp_q <= 2'h0;
            rrp_q <= 2'h0;
            rcnt_q <= 3'h0; // see [RQ14]
            rhead_q <= 11'h000;
        end else if (!en) begin
            rst_q <= RX_IDLE; // see [RQ5]
            rwp_q <= 2'h0; // see [RQ3]
            rrp_q <= 2'h0;
            rcnt_q <= 3'h0;
            rferr_q <= 1'b0;
            rhead_q <= 11'h000; // see [RQ4]
        end else begin
            if (rpop) begin // see [RQ18]
                rhead_q <= rfifo[rrp_q];
                rrp_q <= rrp_q + 2'h1;
            end
            if (rpush) begin
                rwp_q <= rwp_q + 2'h1;
            end
            if (rpush && !rpop) begin
                rcnt_q <= rcnt_q + 3'h1;
            end else if (rpop && !rpush) begin
                rcnt_q <= rcnt_q - 3'h1;
            end
            if (tick) begin
                rph_q <= rph_q + 4'h1;
            end
            case (rst_q)
                RX_IDLE: begin
                    if (!rin_q && !rx_overrun_flag_q) begin // see [RQ23]
                        rst_q <= RX_DATA;
                        rph_q <= 4'h0;
                        rbit_q <= 4'h0;
                        rferr_q <= 1'b0;
                    end
                end
                RX_DATA: begin
                    if (rsamp) begin
                        if (rbit_q == 4'h0 && rin_q) begin
                            rst_q <= RX_IDLE;
                        end else begin
                            if (rbit_q < rstop1) begin
                                rsh_q <= {rin_q, rsh_q[10:1]};
                            end else if (!rin_q) begin
                                rferr_q <= 1'b1;
                            end
                            rbit_q <= rbit_q + 4'h1;
                            // Break must see a high line before rearming
                            if (rdone) begin
                                rst_q <= rstopbad ? RX_WAIT : RX_IDLE;
                            end
                        end
                    end
                end
                RX_WAIT: begin
                    if (rin_q) begin
                        rst_q <= RX_IDLE;
                    end
                end
                default: rst_q <= RX_IDLE;
            endcase
        end
    end
    // Holding the previous head on an empty pop gives stale data
    reg [10:0] rdat_now;
    always @* begin
        rdat_now = rhead_q;
    end
    // Count after the push decides the 3- and 4-word select levels
    wire [2:0] rnext = rcnt_q + 3'h1;
    wire rx_ev = rpush && (!rxisel_q[1] || (rxisel_q[0] ? rnext == `AST_FIFO_DEPTH
        : rnext == `AST_FIFO_3)); // see [RQ22]
    wire rx_rdy = rcnt_q != 3'h0; // see [RQ20]
    assign o_tx_irq = tx_ev; // see [RQ24]
    assign o_rx_irq = rx_ev; // see [RQ24]

    // Control registers; overrun set wins over a software clear
    wire ovr_ev = rdone && rcnt_q == `AST_FIFO_DEPTH && !rx_overrun_flag_q; // see [RQ23]
    wire wr_sta = i_wr && i_addr == `AST_ADDR_STAT;
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_q <= `AST_MODE_RST; // see [RQ2] [RQ8]
            baud_q <= 16'h0000;
            txisel_q <= 1'b0;
            brk_q <= 1'b0;
            txen_q <= 1'b0;
            address_detect_enable_q <= 1'b0;
            rxisel_q <= 2'h0;
            rx_overrun_flag_q <= 1'b0;
        end else begin
            if (i_wr && i_addr == `AST_ADDR_MODE) begin
                mode_q <= i_wdata & 16'h8007;
            end
            if (i_wr && i_addr == `AST_ADDR_BAUD) begin
                baud_q <= i_wdata;
            end
            if (wr_sta) begin
                txisel_q <= i_wdata[`AST_STA_TXISEL];
                rxisel_q <= i_wdata[7:6];
                address_detect_enable_q <= i_wdata[`AST_STA_ADDRESS_DETECT_ENABLE];
            end
            if (!en) begin
                brk_q <= 1'b0; // see [RQ4]
                txen_q <= 1'b0;
                rx_overrun_flag_q <= 1'b0;
            end else begin
                if (wr_sta) begin
                    brk_q <= i_wdata[`AST_STA_BRK];
                    txen_q <= i_wdata[`AST_STA_TXEN];
                end
                if (ovr_ev) begin
                    rx_overrun_flag_q <= 1'b1; // see [RQ19]
                end else if (wr_sta && !i_wdata[`AST_STA_RX_OVERRUN_FLAG]) begin
                    rx_overrun_flag_q <= 1'b0;
                end
            end
        end
    end

    // Status shows the disabled values at once, not a cycle later when the flops clear
    wire st_brk = brk_q && en;
    wire st_txen = txen_q && en;
    wire st_tfull = tfull && en;
    wire st_tempty = !tbusy_q || !en;
    wire st_receiver_idle = rst_q == RX_IDLE || !en;
    wire st_parity_error_flag = rdat_now[10] && en;
    wire st_stop_bit_error = rdat_now[9] && en;
    wire st_rx_overrun_flag = rx_overrun_flag_q && en;
    wire st_rxda = rx_rdy && en;
    wire [15:0] sta = {txisel_q, 3'h0, st_brk, st_txen, st_tfull, st_tempty, rxisel_q,
        address_detect_enable_q, st_receiver_idle, st_parity_error_flag, st_stop_bit_error, st_rx_overrun_flag, st_rxda}; // see [RQ4]
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            case (i_addr)
                `AST_ADDR_MODE: o_rdata <= mode_q;
                `AST_ADDR_STAT: o_rdata <= sta;
                `AST_ADDR_RXD: o_rdata <= rpop ? {7'h00, rfifo[rrp_q][8:0]}
                    : {7'h00, rhead_q[8:0]};
                `AST_ADDR_BAUD: o_rdata <= baud_q;
                default: o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end
endmodule // ast_uart

// >>> tb/ast_uart_assertions.sv
// Port-level checker for the serial transceiver, bound to its top module
`timescale 1ns/100ps
module ast_uart_chk (
    input wire i_mclk, // clock
    input wire i_resetn, // reset, low
    input wire [3:0] i_addr, // index
    input wire [15:0] i_wdata, // wdata
    input wire i_wr, // write
    input wire i_rd, // read
    input wire [15:0] o_rdata, // rdata
    input wire i_serial_in_pin, // rx line
    input wire o_serial_out_pin, // tx line
    input wire o_serial_out_oe, // tx owned
    input wire o_serial_in_own, // rx owned
    input wire o_tx_irq, // tx pulse
    input wire o_rx_irq // rx pulse
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);
    en_owns_pins_a: assert property (i_wr && i_addr == 4'h0
        |=> o_serial_out_oe == $past(i_wdata[15]))
        else $error("tx pin ownership does not follow enable");
    idle_high_a: assert property (!o_serial_out_oe |-> o_serial_out_pin)
        else $error("tx line not high while released");
    own_match_a: assert property (o_serial_in_own == o_serial_out_oe)
        else $error("rx and tx ownership differ");
    tx_pulse_a: assert property (o_tx_irq |=> !o_tx_irq)
        else $error("tx pulse longer than one cycle");
    rx_pulse_a: assert property (o_rx_irq |=> !o_rx_irq)
        else $error("rx pulse longer than one cycle");
    off_status_a: assert property (i_rd && i_addr == 4'h1 && !o_serial_out_oe
        |=> (o_rdata & 16'h0F1F) == 16'h0110)
        else $error("status flags wrong while disabled");
    break_low_a: assert property (i_wr && i_addr == 4'h1 && i_wdata[11]
        && o_serial_out_oe |=> !o_serial_out_pin)
        else $error("break does not pull tx low");
    low_bit_hold_a: assert property ($fell(o_serial_out_pin) && o_serial_out_oe
        |=> (!o_serial_out_pin || !o_serial_out_oe) [*8])
        else $error("low tx bit shorter than a bit time");
endmodule // ast_uart_chk

bind ast_uart ast_uart_chk i_chk (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_serial_in_pin(i_serial_in_pin), .o_serial_out_pin(o_serial_out_pin),
    .o_serial_out_oe(o_serial_out_oe), .o_serial_in_own(o_serial_in_own),
    .o_tx_irq(o_tx_irq), .o_rx_irq(o_rx_irq));

// >>> tb/ast_peer.sv
// Remote serial device: frame sender and mid-bit frame catcher
`timescale 1ns/100ps
module ast_peer #(
    parameter BIT = 32
) (
    input wire i_mclk, // bit timer clock
    input wire i_line, // line from transceiver
    output reg o_line // line into transceiver
);
    reg [15:0] got [$];
    reg [15:0] v;
    integer n_cap;
    integer k;
    initial begin
        o_line = 1'b1;
        n_cap = 9;
    end
    // Bits after the start are kept LSB first, stops included
    always begin
        @(negedge i_line);
        repeat (BIT / 2) @(posedge i_mclk);
        v = 16'h0000;
        for (k = 0; k < n_cap; k = k + 1) begin
            repeat (BIT) @(posedge i_mclk);
            v[k] = i_line;
        end
        got.push_back(v);
    end
    task send(input [15:0] bits, input integer n);
        integer j;
        @(posedge i_mclk);
        o_line <= 1'b0;
        repeat (BIT) @(posedge i_mclk);
        for (j = 0; j < n; j = j + 1) begin
            o_line <= bits[j];
            repeat (BIT) @(posedge i_mclk);
        end
        o_line <= 1'b1;
        repeat (BIT) @(posedge i_mclk);
    endtask
endmodule // ast_peer

// >>> tb/test_async_serial_transceiver.sv
// Self-checking bench for the serial transceiver
`timescale 1ns/100ps
module test_async_serial_transceiver;
    localparam BIT = 32;
    reg i_mclk = 1'b0;
    reg i_resetn = 1'b0;
    reg [3:0] i_addr = 4'h0;
    reg [15:0] i_wdata = 16'h0000;
    reg i_wr = 1'b0;
    reg i_rd = 1'b0;
    wire [15:0] o_rdata;
    wire rx_line, tx_line, tx_oe, rx_own, tx_irq, rx_irq;
    integer err_total = 0;
    integer checked = 0;
    integer cyc = 0;
    integer n_txi = 0;
    integer n_rxi = 0;
    integer f, j, pos;
    reg [15:0] s, d, e, w;
    reg [1:0] sel;
    always #50 i_mclk = ~i_mclk;
    ast_uart i_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_serial_in_pin(rx_line),
        .o_serial_out_pin(tx_line), .o_serial_out_oe(tx_oe), .o_serial_in_own(rx_own),
        .o_tx_irq(tx_irq), .o_rx_irq(rx_irq));
    ast_peer #(.BIT(BIT)) i_peer (.i_mclk(i_mclk), .i_line(tx_line), .o_line(rx_line));
    task complete_run;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Pulses are counted on the edge after they appear, so none is missed
    always @(posedge i_mclk) begin
        cyc = cyc + 1;
        if (tx_irq === 1'b1) n_txi = n_txi + 1;
        if (rx_irq === 1'b1) n_rxi = n_rxi + 1;
        if (cyc == 30000) begin
            err_total = err_total + 1;
            complete_run;
        end
    end
    task wr(input [3:0] a, input [15:0] v);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task rd(input [3:0] a, output [15:0] v);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    task chk(input string n, input [15:0] seen, input [15:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // A missing frame leaves the queue short and the compare fails
    task wait_got(input integer n);
        repeat (20 * BIT * n) if (i_peer.got.size() < n) @(posedge i_mclk);
    endtask
    initial begin
        repeat (4) @(posedge i_mclk);
        i_resetn <= 1'b1;
        rd(4'h0, d);
        chk("mode reset", d, 16'h0000);
        rd(4'h1, s);
        chk("status reset", s, 16'h0110);
        chk("tx line reset", {14'h0, tx_oe, tx_line}, 16'h0001);
        wr(4'h4, 16'h0001);
        for (f = 0; f < 4; f = f + 1) begin
            w = {13'h0, f[1:0], f[0]};
            wr(4'h0, w);
            wr(4'h0, w | 16'h8000);
            wr(4'h1, 16'h0400);
            chk("rx owned", {15'h0, rx_own}, 16'h0001);
            d = (f == 3) ? 16'h01A5 : 16'h00A5;
            e = d;
            pos = (f == 3) ? 9 : 8;
            if (f == 1 || f == 2) begin
                e[pos] = ^d[7:0] ^ (f == 2);
                pos = pos + 1;
            end
            e[pos] = 1'b1;
            e[pos + f[0]] = 1'b1;
            i_peer.n_cap = pos + 1 + f[0];
            i_peer.got.delete();
            wr(4'h2, d);
            wait_got(1);
            chk("frame", i_peer.got[0], e);
        end
        chk("tx pulses each", n_txi[15:0], 16'h0004);
        wr(4'h0, 16'h0000);
        wr(4'h0, 16'h8000);
        wr(4'h1, 16'h8400);
        i_peer.n_cap = 9;
        i_peer.got.delete();
        n_txi = 0;
        for (j = 0; j < 6; j = j + 1) wr(4'h2, 16'h0030 + j[15:0]);
        rd(4'h1, s);
        chk("tx full", {15'h0, s[9]}, 16'h0001);
        wait_got(5);
        repeat (20 * BIT) @(posedge i_mclk);
        w = 16'(i_peer.got.size());
        chk("frames sent", w, 16'h0005);
        for (j = 0; j < 5; j = j + 1) begin
            chk("burst", i_peer.got[j], 16'h0130 + j[15:0]);
        end
        chk("tx pulses empty", n_txi[15:0], 16'h0002);
        for (f = 0; f < 3; f = f + 1) begin
            sel = (f == 0) ? 2'h0 : f[1:0] + 2'h1;
            wr(4'h1, {8'h04, sel, 6'h00});
            n_rxi = 0;
            for (j = 0; j < 4 + f / 2; j = j + 1) i_peer.send({8'h01, 8'hC0 + j[7:0]}, 9);
            repeat (BIT) @(posedge i_mclk);
            chk("rx pulses", n_rxi[15:0], (f == 0) ? 16'h0004 : 16'h0001);
            rd(4'h1, s);
            chk("overrun", {14'h0, s[1:0]}, {14'h0, f == 2, 1'b1});
            for (j = 0; j < 4; j = j + 1) begin
                rd(4'h3, d);
                chk("rx word", d, 16'h00C0 + j[15:0]);
            end
            rd(4'h1, s);
            if (f < 2) begin
                chk("rx drained", {15'h0, s[0]}, 16'h0000);
                rd(4'h3, d);
                chk("stale word", d, 16'h00C3);
            end else
                chk("overrun held", {15'h0, s[1]}, 16'h0001);
        end
        n_txi = 0;
        wr(4'h1, 16'h0CC0);
        repeat (14 * BIT) @(posedge i_mclk);
        chk("break level", {15'h0, tx_line}, 16'h0000);
        wr(4'h1, 16'h04C0);
        repeat (2 * BIT) @(posedge i_mclk);
        chk("after break", {15'h0, tx_line}, 16'h0001);
        chk("break pulses", n_txi[15:0], 16'h0000);
        // Even parity with a wrong parity bit: the popped word carries the flag
        wr(4'h0, 16'h8002);
        i_peer.send(16'h035A, 10);
        repeat (BIT) @(posedge i_mclk);
        rd(4'h3, d);
        chk("rx parity word", d, 16'h005A);
        rd(4'h1, s);
        chk("parity flag", {14'h0, s[3:2]}, 16'h0002);
        i_peer.send(16'h0177, 9);
        wr(4'h2, 16'h0055);
        repeat (3 * BIT) @(posedge i_mclk);
        wr(4'h0, 16'h0000);
        @(negedge i_mclk);
        chk("pins released", {13'h0, tx_oe, rx_own, tx_line}, 16'h0001);
        rd(4'h1, s);
        chk("status disabled", s & 16'h0FDF, 16'h01D0);
        rd(4'h4, d);
        chk("divisor kept", d, 16'h0001);
        complete_run;
    end
endmodule // test_async_serial_transceiver
